// ---- common/pei_pkg.sv ----
package pei_pkg;

  // ----------------------------------------------------------------
  // management addresses
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_IRQ_CTRL  = 5'h11;
  localparam logic [4:0] ADDR_EVT_STAT  = 5'h12;
  localparam logic [4:0] ADDR_PAGE_SEL  = 5'h13;
  localparam logic [4:0] ADDR_FC_COUNT  = 5'h14;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  // event bit order, shared by pending [15:8] and enables [7:0]
  localparam int BIT_LINK_QUALITY  = 7;
  localparam int BIT_ENERGY_DETECT = 6;
  localparam int BIT_LINK_CHANGE   = 5;
  localparam int BIT_SPEED_CHANGE  = 4;
  localparam int BIT_DUPLEX_CHANGE = 3;
  localparam int BIT_AUTONEG_DONE  = 2;
  localparam int BIT_FC_HALF       = 1;
  localparam int BIT_RX_ERR_HALF   = 0;
  localparam int PEND_LSB          = 8;
  localparam int NUM_EVENTS        = 8;

  localparam int BIT_TEST_IRQ      = 2;
  localparam int BIT_MASTER_EN     = 1;
  localparam int BIT_PIN_OE        = 0;
  localparam int CTRL_W            = 3;
  localparam int PAGE_W            = 2;
  localparam int FC_W              = 8;
  localparam int FC_HALF_BIT       = 7;

  // ----------------------------------------------------------------
  // reset values and encodings
  // ----------------------------------------------------------------
  localparam logic [7:0]        RST_EVT_EN   = 8'h00;
  localparam logic [7:0]        RST_PENDING  = 8'h00;
  localparam logic [CTRL_W-1:0] RST_CTRL     = 3'h0;
  localparam logic [FC_W-1:0]   RST_FC_COUNT = 8'h00;
  localparam logic [FC_W-1:0]   FC_MAX       = 8'hFF;
  localparam logic [1:0]        PAGE_EXT0    = 2'h0;
  localparam logic [1:0]        PAGE_DIAG    = 2'h2;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } pei_req_t;

  typedef struct packed {
    logic link_quality;
    logic energy_detect;
    logic link_change;
    logic speed_change;
    logic duplex_change;
    logic autoneg_done;
    logic rx_err_half;
    logic false_carrier;
  } pei_evt_t;

endpackage : pei_pkg

// ---- logic/pei_event_irq.sv ----
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - a pending bit sets when its event occurred since the last status read.
// - an event whose own enable is set raises the interrupt.
// - the interrupt also needs the device-level controls in the control register.
// - pending bits set whether or not their enable is set.
// - bit 15 shows link quality pending, cleared by the read returning it.
// - bit 14 shows energy detect pending, cleared by its read.
// - bit 13 shows link status change pending, cleared by its read.
// - bit 12 shows speed change pending, cleared by its read.
// - bit 11 shows duplex change pending, cleared by its read.
// - bit 10 shows autonegotiation done pending, cleared by its read.
// - bit 9 shows false carrier half-full pending, cleared by its read.
// - bit 8 shows receive error half-full pending, cleared by its read.
// - bits 7:0 are per-event enables, read-write, reset to zero.
// - page field bits 1:0, reset zero, selects bank at addresses 14h..1Fh.
// - page 0 is extended bank, page 2 diagnostics, page 1 reserved.
// - reserved upper bits of page and counter registers read zero.
// - eight-bit false carrier counter counts each false carrier event.
// - the counter saturates at FFh instead of wrapping.
// - the counter is read-only and cleared by the read returning it.
// - a master enable bit, reset zero, gates all event interrupts.
// - while the test bit is set an interrupt is generated regardless.
// - output-enable bit makes the shared pin an interrupt output, else input.
module pei_event_irq
  import pei_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        srst,
  // management register port
  input  wire pei_req_t    mgmt_req,
  output logic [15:0]      rd_data_r,
  output logic             rd_valid_r,
  output logic             rd_hit_r,
  // event pulses from the port
  input  wire pei_evt_t    evt,
  // shared power-down / interrupt pin
  input  wire logic        pin_i,
  output logic             pin_o,
  output logic             pin_oe,
  // status toward the port
  output logic             irq,
  output logic             powerdown_req,
  output logic [1:0]       page_sel
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0]        evt_en_r;
  logic [7:0]        pending_r;
  logic [7:0]        pending_nxt;
  logic [CTRL_W-1:0] ctrl_r;
  logic [PAGE_W-1:0] page_r;
  logic [FC_W-1:0]   fc_count_r;
  logic [FC_W-1:0]   fc_count_nxt;
  logic [7:0]        evt_vec;
  logic              fc_half_evt;
  logic              rd_evt;
  logic              rd_fc;
  logic              page0;
  logic              pin_s1_r;
  logic              pin_s2_r;

  assign page0  = (page_r == PAGE_EXT0);
  assign rd_evt = mgmt_req.rd && (mgmt_req.addr == ADDR_EVT_STAT);
  // the counter is only visible in the extended page-0 bank
  assign rd_fc  = mgmt_req.rd && (mgmt_req.addr == ADDR_FC_COUNT)
                  && page0;

  // ----------------------------------------------------------------
  // false carrier counter
  // ----------------------------------------------------------------
  always_comb begin
    if (rd_fc) begin
      // a read returns the value and restarts; a coincident event counts
      fc_count_nxt = evt.false_carrier ? 8'h01 : RST_FC_COUNT;
    end else if (evt.false_carrier && fc_count_r != FC_MAX) begin
      fc_count_nxt = FC_W'(fc_count_r + 8'h01);
    end else begin
      fc_count_nxt = fc_count_r;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      fc_count_r <= RST_FC_COUNT;
    end else begin
      fc_count_r <= fc_count_nxt;
    end
  end

  // half-full: top bit going from clear to set
  assign fc_half_evt = !fc_count_r[FC_HALF_BIT]
                       && fc_count_nxt[FC_HALF_BIT];

  // ----------------------------------------------------------------
  // pending event bits
  // ----------------------------------------------------------------
  always_comb begin
    evt_vec                    = 8'h00;
    evt_vec[BIT_LINK_QUALITY]  = evt.link_quality;
    evt_vec[BIT_ENERGY_DETECT] = evt.energy_detect;
    evt_vec[BIT_LINK_CHANGE]   = evt.link_change;
    evt_vec[BIT_SPEED_CHANGE]  = evt.speed_change;
    evt_vec[BIT_DUPLEX_CHANGE] = evt.duplex_change;
    evt_vec[BIT_AUTONEG_DONE]  = evt.autoneg_done;
    evt_vec[BIT_FC_HALF]       = fc_half_evt;
    evt_vec[BIT_RX_ERR_HALF]   = evt.rx_err_half;
  end

  // set wins over the read clear; enables play no part here
  assign pending_nxt = (rd_evt ? RST_PENDING : pending_r)
                       | evt_vec;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pending_r <= RST_PENDING;
    end else begin
      pending_r <= pending_nxt;
    end
  end

  // ----------------------------------------------------------------
  // writable controls
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      evt_en_r <= RST_EVT_EN;
    end else if (mgmt_req.wr && mgmt_req.addr == ADDR_EVT_STAT) begin
      // upper byte is status only, writes there are dropped
      evt_en_r <= mgmt_req.wdata[7:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl_r <= RST_CTRL;
    end else if (mgmt_req.wr && mgmt_req.addr == ADDR_IRQ_CTRL) begin
      ctrl_r <= mgmt_req.wdata[CTRL_W-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      page_r <= PAGE_EXT0;
    end else if (mgmt_req.wr && mgmt_req.addr == ADDR_PAGE_SEL) begin
      // value 1 is stored as written; nothing answers on it
      page_r <= mgmt_req.wdata[PAGE_W-1:0];
    end
  end

  assign page_sel = page_r;

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rd_data_r  <= 16'h0000;
      rd_valid_r <= 1'b0;
      rd_hit_r   <= 1'b0;
    end else begin
      rd_valid_r <= mgmt_req.rd;
      rd_hit_r   <= 1'b0;
      rd_data_r  <= 16'h0000;
      if (mgmt_req.rd) begin
        if (mgmt_req.addr == ADDR_EVT_STAT) begin
          rd_data_r <= {pending_r, evt_en_r};
          rd_hit_r  <= 1'b1;
        end else if (mgmt_req.addr == ADDR_IRQ_CTRL) begin
          rd_data_r <= {13'h0000, ctrl_r};
          rd_hit_r  <= 1'b1;
        end else if (mgmt_req.addr == ADDR_PAGE_SEL) begin
          rd_data_r <= {14'h0000, page_r};
          rd_hit_r  <= 1'b1;
        end else if (rd_fc) begin
          rd_data_r <= {8'h00, fc_count_r};
          rd_hit_r  <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt and shared pin
  // ----------------------------------------------------------------
  // level output: with the master enable set, stays up while any enabled bit is pending
  assign irq = ctrl_r[BIT_TEST_IRQ]
               || (ctrl_r[BIT_MASTER_EN]
                   && |(pending_r & evt_en_r));

  // pin is active low in both roles
  assign pin_oe = ctrl_r[BIT_PIN_OE];
  assign pin_o  = !irq;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pin_s1_r <= 1'b1;
      pin_s2_r <= 1'b1;
    end else begin
      pin_s1_r <= pin_i;
      pin_s2_r <= pin_s1_r;
    end
  end

  // while the pin is an output its level is our own, not a request
  assign powerdown_req = !pin_oe && !pin_s2_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  sequence s_status_read;
    mgmt_req.rd && mgmt_req.addr == ADDR_EVT_STAT;
  endsequence

  sequence s_fc_read;
    mgmt_req.rd && mgmt_req.addr == ADDR_FC_COUNT && page_r == PAGE_EXT0;
  endsequence

  property p_evt_kept;
    evt.link_change |=> pending_r[BIT_LINK_CHANGE] [*1]
      ##1 (pending_r[BIT_LINK_CHANGE] || $past(rd_evt));
  endproperty
  a_evt_kept: assert property (p_evt_kept)
    else $error("link change event not held pending");

  property p_clear_on_read;
    s_status_read ##0 (evt_vec == 8'h00) |=> pending_r == 8'h00;
  endproperty
  a_clear_on_read: assert property (p_clear_on_read)
    else $error("status read did not clear pending bits");

  property p_read_returns;
    s_status_read |=> rd_valid_r && rd_hit_r
      && rd_data_r[15:8] == $past(pending_r)
      && rd_data_r[7:0] == $past(evt_en_r);
  endproperty
  a_read_returns: assert property (p_read_returns)
    else $error("status read returned wrong value");

  property p_irq_follows;
    ctrl_r[BIT_MASTER_EN] && evt_en_r[BIT_SPEED_CHANGE] && evt.speed_change
      && !mgmt_req.wr |=> irq;
  endproperty
  a_irq_follows: assert property (p_irq_follows)
    else $error("enabled event did not raise interrupt");

  property p_master_gate;
    !ctrl_r[BIT_MASTER_EN] && !ctrl_r[BIT_TEST_IRQ] |-> !irq;
  endproperty
  a_master_gate: assert property (p_master_gate)
    else $error("interrupt without master enable");

  property p_test_hold;
    ctrl_r[BIT_TEST_IRQ] [*2] |-> irq && $past(irq);
  endproperty
  a_test_hold: assert property (p_test_hold)
    else $error("test bit did not hold interrupt");

  property p_pin_role;
    pin_oe == ctrl_r[BIT_PIN_OE] && (!pin_oe || pin_o == !irq)
      && (powerdown_req == (!pin_oe && !$past(pin_i, 2)));
  endproperty
  a_pin_role: assert property (p_pin_role)
    else $error("shared pin role wrong");

  property p_fc_count;
    evt.false_carrier && !rd_fc && fc_count_r != FC_MAX
      |=> fc_count_r == FC_W'($past(fc_count_r) + 8'h01);
  endproperty
  a_fc_count: assert property (p_fc_count)
    else $error("false carrier counter did not step");

  property p_fc_sat;
    fc_count_r == FC_MAX && !rd_fc |=> fc_count_r == FC_MAX;
  endproperty
  a_fc_sat: assert property (p_fc_sat)
    else $error("false carrier counter left its maximum");

  property p_fc_read;
    s_fc_read ##0 !evt.false_carrier |=> fc_count_r == 8'h00
      && rd_data_r == {8'h00, $past(fc_count_r)};
  endproperty
  a_fc_read: assert property (p_fc_read)
    else $error("counter read wrong or not cleared");

  property p_fc_half;
    fc_count_r == 8'h7F && evt.false_carrier && !rd_fc && !rd_evt
      |=> pending_r[BIT_FC_HALF] ##1 (pending_r[BIT_FC_HALF] || $past(rd_evt));
  endproperty
  a_fc_half: assert property (p_fc_half)
    else $error("half-full event missed");

  property p_page_read;
    mgmt_req.rd && mgmt_req.addr == ADDR_PAGE_SEL
      |=> rd_data_r[15:2] == 14'h0000 && rd_data_r[1:0] == page_r;
  endproperty
  a_page_read: assert property (p_page_read)
    else $error("page register read wrong");

  property p_page_hides_fc;
    mgmt_req.rd && mgmt_req.addr == ADDR_FC_COUNT && page_r != PAGE_EXT0
      |=> !rd_hit_r && rd_data_r == 16'h0000;
  endproperty
  a_page_hides_fc: assert property (p_page_hides_fc)
    else $error("counter answered outside page 0");

endmodule : pei_event_irq

`default_nettype wire

// ---- testbench/pei_station.sv ----
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// management station model
// ------------------------------------------------------------
module pei_station
  import pei_pkg::*;
(
  // clock
  input  wire logic        ref_clk,
  // register port
  output var pei_req_t     mgmt_req,
  input  wire logic [15:0] rd_data_r,
  input  wire logic        rd_valid_r,
  input  wire logic        rd_hit_r
);
  initial mgmt_req = '{rd: 1'b0, wr: 1'b0, addr: 5'h0A, wdata: 16'hA5A5};

  task automatic write_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    mgmt_req.wr    <= 1'b1;
    mgmt_req.addr  <= a;
    mgmt_req.wdata <= d;
    @(posedge ref_clk);
    mgmt_req.wr    <= 1'b0;
    // idle lines never keep the last value, so a stale match shows up
    mgmt_req.addr  <= ~a;
    mgmt_req.wdata <= ~d;
  endtask : write_reg

  task automatic read_reg(input logic [4:0] a, output logic [15:0] d,
                          output logic h, output logic ok);
    ok = 1'b0;
    d  = 16'h0000;
    h  = 1'b0;
    @(posedge ref_clk);
    mgmt_req.rd   <= 1'b1;
    mgmt_req.addr <= a;
    @(posedge ref_clk);
    mgmt_req.rd   <= 1'b0;
    mgmt_req.addr <= ~a;
    for (int i = 0; i < 4; i++) begin
      #1;
      if (rd_valid_r === 1'b1) begin
        ok = 1'b1;
        d  = rd_data_r;
        h  = rd_hit_r;
        break;
      end
      @(posedge ref_clk);
    end
  endtask : read_reg
endmodule : pei_station

`default_nettype wire

// ---- testbench/phy_event_interrupt_status_test.sv ----
`timescale 1ns/1ps
`default_nettype none

module phy_event_interrupt_status_test
  import pei_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        srst    = 1'b1;
  pei_req_t    mgmt_req;
  logic [15:0] rd_data_r;
  logic        rd_valid_r;
  logic        rd_hit_r;
  pei_evt_t    evt     = '0;
  logic        pd_drive = 1'b1;
  logic        pin_i;
  logic        pin_o;
  logic        pin_oe;
  logic        irq;
  logic        powerdown_req;
  logic [1:0]  page_sel;
  int          n_mismatch = 0;
  int          tests_run  = 0;

  // pin pulled high by the board; the device wins while it drives
  assign pin_i = pin_oe ? pin_o : pd_drive;
  always #12.5 ref_clk = ~ref_clk;

  pei_event_irq u_pei_event_irq (
    .ref_clk(ref_clk), .srst(srst), .mgmt_req(mgmt_req),
    .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r), .rd_hit_r(rd_hit_r),
    .evt(evt), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .irq(irq),
    .powerdown_req(powerdown_req), .page_sel(page_sel));

  pei_station u_pei_station (
    .ref_clk(ref_clk), .mgmt_req(mgmt_req), .rd_data_r(rd_data_r),
    .rd_valid_r(rd_valid_r), .rd_hit_r(rd_hit_r));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic results();
    $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      $display("unexpected %s exp %h got %h", n, e, g);
      n_mismatch++;
    end
  endtask : chk

  task automatic chkb(input string n, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      $display("unexpected %s exp %b got %b", n, e, g);
      n_mismatch++;
    end
  endtask : chkb

  task automatic rd(input logic [4:0] a, input logic [15:0] e, input logic eh);
    logic [15:0] d;
    logic        h;
    logic        ok;
    u_pei_station.read_reg(a, d, h, ok);
    chkb("read answer", 1'b1, ok);
    if (ok !== 1'b1) results();
    chkb("rd_hit", eh, h);
    chk("rd_data", e, d);
  endtask : rd

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    u_pei_station.write_reg(a, d);
    #1;
  endtask : wr

  task automatic pulse(input pei_evt_t e, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      evt <= e;
      @(posedge ref_clk);
      evt <= '0;
    end
    #1;
  endtask : pulse

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    rd(ADDR_IRQ_CTRL, 16'h0000, 1'b1);
    rd(ADDR_EVT_STAT, 16'h0000, 1'b1);
    rd(ADDR_PAGE_SEL, 16'h0000, 1'b1);
    rd(ADDR_FC_COUNT, 16'h0000, 1'b1);
    chkb("pin_oe", 1'b0, pin_oe);
    chkb("pin_o", 1'b1, pin_o);
    rd(5'h1F, 16'h0000, 1'b0);
    wr(ADDR_EVT_STAT, 16'hFFFF);
    rd(ADDR_EVT_STAT, 16'h00FF, 1'b1);
    wr(ADDR_EVT_STAT, 16'h0000);
  endtask : t_reset

  task automatic t_pending();
    logic [15:0] e;
    for (int i = 7; i >= 1; i--) begin
      e = 16'h0001 << ((i == 1) ? 8 : 8 + i);
      pulse(pei_evt_t'(8'h01 << i), 1);
      chkb("irq masked", 1'b0, irq);
      rd(ADDR_EVT_STAT, e, 1'b1);
      rd(ADDR_EVT_STAT, 16'h0000, 1'b1);
    end
  endtask : t_pending

  task automatic t_irq();
    wr(ADDR_EVT_STAT, 16'h0030);
    pulse(pei_evt_t'(8'h20), 1);
    chkb("irq no master", 1'b0, irq);
    wr(ADDR_IRQ_CTRL, 16'h0002);
    chkb("irq", 1'b1, irq);
    wr(ADDR_IRQ_CTRL, 16'h0003);
    chkb("pin_oe", 1'b1, pin_oe);
    chkb("pin_o", 1'b0, pin_o);
    // speed event with master and its own enable on
    pulse(pei_evt_t'(8'h10), 1);
    chkb("irq speed", 1'b1, irq);
    rd(ADDR_EVT_STAT, 16'h3030, 1'b1);
    chkb("irq cleared", 1'b0, irq);
    wr(ADDR_IRQ_CTRL, 16'h0004);
    chkb("irq test", 1'b1, irq);
    wr(ADDR_IRQ_CTRL, 16'h0000);
    chkb("irq off", 1'b0, irq);
    wr(ADDR_EVT_STAT, 16'h0000);
  endtask : t_irq

  task automatic t_race();
    pulse(pei_evt_t'(8'h40), 1);
    fork
      rd(ADDR_EVT_STAT, 16'h4000, 1'b1);
      begin
        @(posedge ref_clk);
        evt <= pei_evt_t'(8'h40);
        @(posedge ref_clk);
        evt <= '0;
      end
    join
    rd(ADDR_EVT_STAT, 16'h4000, 1'b1);
    rd(ADDR_EVT_STAT, 16'h0000, 1'b1);
  endtask : t_race

  task automatic t_counter();
    pulse(pei_evt_t'(8'h01), 127);
    rd(ADDR_EVT_STAT, 16'h0000, 1'b1);
    pulse(pei_evt_t'(8'h01), 1);
    rd(ADDR_EVT_STAT, 16'h0200, 1'b1);
    pulse(pei_evt_t'(8'h01), 200);
    wr(ADDR_FC_COUNT, 16'h0000);
    rd(ADDR_FC_COUNT, 16'h00FF, 1'b1);
    rd(ADDR_FC_COUNT, 16'h0000, 1'b1);
    // a nonzero count shows that hidden reads do not clear it
    pulse(pei_evt_t'(8'h01), 3);
    wr(ADDR_PAGE_SEL, 16'hFFFE);
    rd(ADDR_PAGE_SEL, 16'h0002, 1'b1);
    chk("page_sel", {14'h0, PAGE_DIAG}, {14'h0, page_sel});
    rd(ADDR_FC_COUNT, 16'h0000, 1'b0);
    wr(ADDR_PAGE_SEL, 16'h0001);
    rd(ADDR_PAGE_SEL, 16'h0001, 1'b1);
    rd(ADDR_FC_COUNT, 16'h0000, 1'b0);
    wr(ADDR_PAGE_SEL, 16'h0000);
    fork
      rd(ADDR_FC_COUNT, 16'h0003, 1'b1);
      pulse(pei_evt_t'(8'h01), 1);
    join
    rd(ADDR_FC_COUNT, 16'h0001, 1'b1);
  endtask : t_counter

  task automatic t_pin();
    @(posedge ref_clk);
    pd_drive <= 1'b0;
    for (int i = 0; i < 6 && powerdown_req !== 1'b1; i++) @(posedge ref_clk);
    #1;
    chkb("powerdown_req", 1'b1, powerdown_req);
    @(posedge ref_clk);
    pd_drive <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    chkb("powerdown_req released", 1'b0, powerdown_req);
    // as an output the pin level is ignored as a request
    wr(ADDR_IRQ_CTRL, 16'h0001);
    @(posedge ref_clk);
    pd_drive <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    chkb("powerdown_req as output", 1'b0, powerdown_req);
    chkb("pin_o idle", 1'b1, pin_o);
    @(posedge ref_clk);
    pd_drive <= 1'b1;
    wr(ADDR_IRQ_CTRL, 16'h0000);
  endtask : t_pin

  initial begin
    repeat (4) @(posedge ref_clk);
    srst <= 1'b0;
    t_reset();
    t_pending();
    t_irq();
    t_race();
    t_counter();
    t_pin();
    results();
  end
endmodule : phy_event_interrupt_status_test

`default_nettype wire
